// ### rtl/lpps_pkg.sv
package lpps_pkg;

	// Clock and time base.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_W        = 20;

	// Loss-of-signal window, in milliseconds.
	localparam int unsigned LOS_MS = 28;
	localparam int unsigned LOS_W  = 6;

	// Interval width and the fixed interval lengths, in milliseconds.
	localparam int unsigned IV_W       = 9;
	localparam logic [8:0]  IV_ZERO_MS = 9'h000;
	localparam logic [8:0]  IV_32_MS   = 9'h020;
	localparam logic [8:0]  IV_37_MS   = 9'h025;
	localparam logic [8:0]  IV_30_MS   = 9'h01E;

	// Small video panel intervals, inside their permitted windows.
	localparam logic [8:0]  SAV_UP_A_MS = 9'h00A;
	localparam logic [8:0]  SAV_UP_B_MS = 9'h00A;
	localparam logic [8:0]  SAV_UP_C_MS = 9'h005;
	localparam logic [8:0]  SAV_DN_D_MS = 9'h00A;
	localparam logic [8:0]  SAV_DN_E_MS = 9'h00A;
	localparam logic [8:0]  SAV_DN_F_MS = 9'h032;

	// Programmable step sizes and reset defaults of the delay settings.
	localparam int unsigned SEL_W          = 4;
	localparam int unsigned UP_STEP_SHIFT  = 2;
	localparam int unsigned DN_STEP_SHIFT  = 5;
	localparam logic [3:0]  UP_SEL_DEFAULT = 4'h8;
	localparam logic [3:0]  DN_SEL_DEFAULT = 4'h1;

	// Number of monitored video signals.
	localparam int unsigned NUM_MON = 2;

	// Timing variant of the sequencer.
	typedef enum logic [2:0] {
		LPPS_MODE_FIXED32,
		LPPS_MODE_PROG,
		LPPS_MODE_FIXED37,
		LPPS_MODE_SINGLE30,
		LPPS_MODE_SMALL_AV
	} lpps_mode_e;

	// Sequencing steps that own an interval.
	typedef enum logic [2:0] {
		LPPS_STEP_UP_A,
		LPPS_STEP_UP_B,
		LPPS_STEP_UP_C,
		LPPS_STEP_DN_D,
		LPPS_STEP_DN_E,
		LPPS_STEP_DN_F
	} lpps_step_e;

	// Sequencer states.
	typedef enum logic [2:0] {
		LPPS_ST_OFF,
		LPPS_ST_UP_LOGIC,
		LPPS_ST_UP_VIDEO,
		LPPS_ST_UP_BIAS,
		LPPS_ST_ON,
		LPPS_ST_DN_VIDEO,
		LPPS_ST_DN_BIAS,
		LPPS_ST_DN_LOGIC
	} lpps_state_e;

	// Supply and drive controls towards the external switches.
	typedef struct packed {
		logic logic_supply_enable;
		logic bias_supply_enable;
		logic source_high_supply;
		logic gate_high_supply;
		logic source_low_supply;
		logic gate_low_supply;
		logic panel_power_sequence_ctl;
		logic video_enable;
	} lpps_supply_s;

	localparam lpps_supply_s SUPPLY_OFF = '0;

	// Video signals watched for activity.
	typedef struct packed {
		logic pixel_clock;
		logic line_sync;
		logic upper_data_clock;
		logic lower_data_clock;
	} lpps_video_s;

endpackage

// ### rtl/lpps_activity.sv
module lpps_activity
	import lpps_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	input  wire logic i_tick,
	input  wire logic i_sig,
	output logic      o_active
);
	import lpps_pkg::*;

	typedef struct packed {
		logic             prev;
		logic [LOS_W-1:0] idle_ms;
		logic             active;
	} lpps_act_s;

	lpps_act_s act_q;
	lpps_act_s act_d;

	// Any edge restarts the idle count; the count saturates past the window
	// so a long silence cannot wrap back into the active range.
	always_comb begin
		act_d      = act_q;
		act_d.prev = i_sig;
		if (i_sig != act_q.prev) begin
			act_d.idle_ms = '0;
		end else if (i_tick && act_q.idle_ms <= LOS_W'(LOS_MS)) begin
			act_d.idle_ms = act_q.idle_ms + LOS_W'(1);
		end
		act_d.active = (act_d.idle_ms <= LOS_W'(LOS_MS));
	end

	// Reset assumes silence, so power never comes up before real activity.
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			act_q.prev    <= 1'b0;
			act_q.idle_ms <= LOS_W'(LOS_MS + 1);
			act_q.active  <= 1'b0;
		end else if (i_ce) begin
			act_q <= act_d;
		end
	end

	assign o_active = act_q.active;

endmodule

// ### rtl/lpps_interval_timer.sv
module lpps_interval_timer
	import lpps_pkg::*;
(
	input  wire logic            i_mclk,
	input  wire logic            i_rst_n,
	input  wire logic            i_ce,
	input  wire logic            i_tick,
	input  wire logic            i_load,
	input  wire logic [IV_W-1:0] i_ms,
	output logic                 o_done
);
	import lpps_pkg::*;

	logic [IV_W-1:0] cnt_q;
	logic [IV_W-1:0] cnt_d;

	// Counts whole milliseconds; a partial first tick makes the interval
	// up to one millisecond short, which every window tolerates.
	always_comb begin
		cnt_d = cnt_q;
		if (i_load) begin
			cnt_d = i_ms;
		end else if (i_tick && cnt_q != '0) begin
			cnt_d = cnt_q - IV_W'(1);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
		end else if (i_ce) begin
			cnt_q <= cnt_d;
		end
	end

	assign o_done = (cnt_q == '0);

endmodule

// ### rtl/lpps_sequencer.sv
module lpps_sequencer
	import lpps_pkg::*;
#(
	parameter int unsigned P_MS_CYCLES = MS_CYCLES
)
(
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	input  wire logic              i_ce,
	input  wire lpps_pkg::lpps_mode_e  i_mode,
	input  wire logic              i_passive_panel,
	input  wire logic              i_power_request,
	input  wire logic [3:0]        i_up_delay_sel,
	input  wire logic [3:0]        i_down_delay_sel,
	input  wire lpps_pkg::lpps_video_s i_video,
	output lpps_pkg::lpps_supply_s o_supply,
	output logic                   o_signals_active,
	output logic                   o_power_good,
	output logic                   o_busy
);
	import lpps_pkg::*;

	// State of the sequencer outside the timer and the detectors, registered as one word.
	typedef struct packed {
		lpps_state_e       state;
		logic [TICK_W-1:0] presc;
		logic              tick;
		lpps_supply_s      supply;
		logic              sig_active;
		logic              power_good;
		logic              busy;
	} lpps_seq_s;

	lpps_seq_s        seq_q;
	lpps_seq_s        seq_d;
	logic             tmr_load;
	logic [IV_W-1:0]  tmr_ms;
	logic             tmr_done;
	logic [NUM_MON-1:0] mon_sig;
	logic [NUM_MON-1:0] mon_active;
	logic             both_active;

	// passive source select
	// Passive panels have no pixel clock worth watching, so the two
	// half-panel shift clocks stand in for clock and sync.
	assign mon_sig[0] = i_passive_panel ? i_video.upper_data_clock
	                                    : i_video.pixel_clock;
	assign mon_sig[1] = i_passive_panel ? i_video.lower_data_clock
	                                    : i_video.line_sync;

	// idle window detectors
	// One detector per watched signal, each with its own idle count.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MON; gi++) begin : g_mon
			lpps_activity u_act (
				.i_mclk   (i_mclk),
				.i_rst_n  (i_rst_n),
				.i_ce     (i_ce),
				.i_tick   (seq_q.tick),
				.i_sig    (mon_sig[gi]),
				.o_active (mon_active[gi])
			);
		end
	endgenerate

	assign both_active = &mon_active;

	// Shared interval timer; only one interval runs at a time.
	lpps_interval_timer u_tmr (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_tick  (seq_q.tick),
		.i_load  (tmr_load),
		.i_ms    (tmr_ms),
		.o_done  (tmr_done)
	);

	// Interval length for a step under the selected timing variant.
	function automatic logic [IV_W-1:0] interval_ms(
		input lpps_mode_e mode,
		input lpps_step_e step,
		input logic [3:0] up_sel,
		input logic [3:0] dn_sel
	);
		logic is_up;
		logic is_third;
		logic [IV_W-1:0] val;
		is_up    = (step == LPPS_STEP_UP_A) || (step == LPPS_STEP_UP_B) ||
		           (step == LPPS_STEP_UP_C);
		is_third = (step == LPPS_STEP_UP_C) || (step == LPPS_STEP_DN_F);
		val      = IV_ZERO_MS;
		case (mode)
			LPPS_MODE_FIXED32: begin
				val = is_third ? IV_ZERO_MS : IV_32_MS;
			end
			LPPS_MODE_PROG: begin
				if (is_third) begin
					val = IV_ZERO_MS;
				end else if (is_up) begin
					val = IV_W'({5'h00, up_sel} << UP_STEP_SHIFT);
				end else begin
					val = IV_W'({5'h00, dn_sel} << DN_STEP_SHIFT);
				end
			end
			LPPS_MODE_FIXED37: begin
				val = is_third ? IV_ZERO_MS : IV_37_MS;
			end
			LPPS_MODE_SINGLE30: begin
				val = is_third ? IV_ZERO_MS : IV_30_MS;
			end
			LPPS_MODE_SMALL_AV: begin
				case (step)
					LPPS_STEP_UP_A: val = SAV_UP_A_MS;
					LPPS_STEP_UP_B: val = SAV_UP_B_MS;
					LPPS_STEP_UP_C: val = SAV_UP_C_MS;
					LPPS_STEP_DN_D: val = SAV_DN_D_MS;
					LPPS_STEP_DN_E: val = SAV_DN_E_MS;
					LPPS_STEP_DN_F: val = SAV_DN_F_MS;
					default:        val = IV_ZERO_MS;
				endcase
			end
			default: begin
				val = IV_32_MS;
			end
		endcase
		return val;
	endfunction

	// Next state of the whole sequencer. The timer is loaded on the same
	// cycle that a state is entered, so its done flag is fresh one cycle on.
	always_comb begin
		seq_d    = seq_q;
		tmr_load = 1'b0;
		tmr_ms   = IV_ZERO_MS;

		// Millisecond tick shared by the timer and the detectors.
		seq_d.tick = 1'b0;
		if (seq_q.presc >= TICK_W'(P_MS_CYCLES - 1)) begin
			seq_d.presc = '0;
			seq_d.tick  = 1'b1;
		end else begin
			seq_d.presc = seq_q.presc + TICK_W'(1);
		end

		case (seq_q.state)
			LPPS_ST_OFF: begin
				if (i_power_request && both_active) begin
					seq_d.state = LPPS_ST_UP_LOGIC;
					seq_d.supply.logic_supply_enable      = 1'b1;
					seq_d.supply.panel_power_sequence_ctl = 1'b1;
					tmr_load = 1'b1;
					tmr_ms   = interval_ms(i_mode, LPPS_STEP_UP_A,
					                       i_up_delay_sel, i_down_delay_sel);
				end
			end
			LPPS_ST_UP_LOGIC: begin
				if (tmr_done) begin
					seq_d.state = LPPS_ST_UP_VIDEO;
					seq_d.supply.video_enable = 1'b1;
					tmr_load = 1'b1;
					tmr_ms   = interval_ms(i_mode, LPPS_STEP_UP_B,
					                       i_up_delay_sel, i_down_delay_sel);
				end
			end
			LPPS_ST_UP_VIDEO: begin
				if (tmr_done) begin
					seq_d.state = LPPS_ST_UP_BIAS;
					seq_d.supply.bias_supply_enable = 1'b1;
					tmr_load = 1'b1;
					tmr_ms   = interval_ms(i_mode, LPPS_STEP_UP_C,
					                       i_up_delay_sel, i_down_delay_sel);
				end
			end
			LPPS_ST_UP_BIAS: begin
				if (tmr_done) begin
					seq_d.state = LPPS_ST_ON;
				end
			end
			LPPS_ST_ON: begin
				if (!i_power_request) begin
					seq_d.state = LPPS_ST_DN_VIDEO;
					seq_d.supply.video_enable = 1'b0;
					tmr_load = 1'b1;
					tmr_ms   = interval_ms(i_mode, LPPS_STEP_DN_D,
					                       i_up_delay_sel, i_down_delay_sel);
				end
			end
			LPPS_ST_DN_VIDEO: begin
				if (tmr_done) begin
					seq_d.state = LPPS_ST_DN_BIAS;
					seq_d.supply.bias_supply_enable = 1'b0;
					tmr_load = 1'b1;
					tmr_ms   = interval_ms(i_mode, LPPS_STEP_DN_E,
					                       i_up_delay_sel, i_down_delay_sel);
				end
			end
			LPPS_ST_DN_BIAS: begin
				if (tmr_done) begin
					seq_d.state = LPPS_ST_DN_LOGIC;
					seq_d.supply.logic_supply_enable      = 1'b0;
					seq_d.supply.panel_power_sequence_ctl = 1'b0;
					tmr_load = 1'b1;
					tmr_ms   = interval_ms(i_mode, LPPS_STEP_DN_F,
					                       i_up_delay_sel, i_down_delay_sel);
				end
			end
			LPPS_ST_DN_LOGIC: begin
				// Hold-off so a small video panel sees a clean off before any restart; the other variants load zero.
				if (tmr_done) begin
					seq_d.state = LPPS_ST_OFF;
				end
			end
			default: begin
				seq_d.state  = LPPS_ST_OFF;
				seq_d.supply = SUPPLY_OFF;
			end
		endcase

		// loss-of-signal shutdown
		// Dropping everything at once, like the relay it replaces, is the
		// safe trade: a panel left biased without clocks sees DC.
		if (!both_active && seq_q.state != LPPS_ST_OFF &&
		    seq_q.state != LPPS_ST_DN_LOGIC) begin
			seq_d.state  = LPPS_ST_DN_LOGIC;
			seq_d.supply = SUPPLY_OFF;
			tmr_load = 1'b1;
			tmr_ms   = interval_ms(i_mode, LPPS_STEP_DN_F,
			                       i_up_delay_sel, i_down_delay_sel);
		end

		seq_d.supply.source_high_supply = seq_d.supply.logic_supply_enable;
		seq_d.supply.gate_high_supply   = seq_d.supply.logic_supply_enable;
		seq_d.supply.source_low_supply  = seq_d.supply.bias_supply_enable;
		seq_d.supply.gate_low_supply    = seq_d.supply.bias_supply_enable;

		// Status flags registered with the state they describe.
		seq_d.sig_active = both_active;
		seq_d.power_good = (seq_d.state == LPPS_ST_ON);
		seq_d.busy       = (seq_d.state != LPPS_ST_ON) &&
		                   (seq_d.state != LPPS_ST_OFF);
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			seq_q.state      <= LPPS_ST_OFF;
			seq_q.presc      <= '0;
			seq_q.tick       <= 1'b0;
			seq_q.supply     <= SUPPLY_OFF;
			seq_q.sig_active <= 1'b0;
			seq_q.power_good <= 1'b0;
			seq_q.busy       <= 1'b0;
		end else if (i_ce) begin
			seq_q <= seq_d;
		end
	end

	assign o_supply         = seq_q.supply;
	assign o_signals_active = seq_q.sig_active;
	assign o_power_good     = seq_q.power_good;
	assign o_busy           = seq_q.busy;

endmodule

// ### verification/lpps_seq_monitor.sv
module lpps_seq_monitor
	import lpps_pkg::*;
#(
	parameter int unsigned P_MS_CYCLES = MS_CYCLES
)
(
	input wire logic                   i_mclk,
	input wire logic                   i_rst_n,
	input wire lpps_pkg::lpps_mode_e   i_mode,
	input wire logic                   i_passive_panel,
	input wire logic                   i_power_request,
	input wire lpps_pkg::lpps_video_s  i_video,
	input wire lpps_pkg::lpps_supply_s o_supply,
	input wire logic                   o_power_good,
	input wire logic                   o_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int UP_LO  = 31 * P_MS_CYCLES;
	localparam int UP_HI  = 32 * P_MS_CYCLES + 3;
	localparam int LOS_HI = 29 * P_MS_CYCLES + 6;
	logic        mon_a;
	logic        mon_b;
	logic        pa_q;
	logic        pb_q;
	logic [31:0] ia_q;
	logic [31:0] ib_q;
	logic [31:0] up_q;

	default clocking mon_cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	// The watched pair swaps with the panel type.
	assign mon_a = i_passive_panel ? i_video.upper_data_clock
		: i_video.pixel_clock;
	assign mon_b = i_passive_panel ? i_video.lower_data_clock
		: i_video.line_sync;

	// Idle ages of the watched lines, and age of the logic rail.
	always_ff @(posedge i_mclk) begin
		pa_q <= mon_a;
		pb_q <= mon_b;
		ia_q <= (mon_a != pa_q || !i_rst_n) ? '0 : ia_q + 32'h0000_0001;
		ib_q <= (mon_b != pb_q || !i_rst_n) ? '0 : ib_q + 32'h0000_0001;
		up_q <= $rose(o_supply.logic_supply_enable) ? '0
			: up_q + 32'h0000_0001;
	end

	sequence s_start_fixed;
		$rose(o_supply.logic_supply_enable) && i_mode == LPPS_MODE_FIXED32;
	endsequence
	sequence s_video_up;
		$rose(o_supply.video_enable) && i_mode == LPPS_MODE_FIXED32;
	endsequence

	a_bias_needs_logic: assert property (
		o_supply.bias_supply_enable |-> o_supply.logic_supply_enable)
		else $error("bias enable without logic enable");
	a_low_after_high: assert property (
		o_supply.source_low_supply |-> o_supply.source_high_supply)
		else $error("low rail on without high rail");
	a_gate_follows: assert property (
		o_supply.gate_high_supply == o_supply.source_high_supply &&
		o_supply.gate_low_supply == o_supply.source_low_supply)
		else $error("gate rail differs from source rail");
	a_bias_after_video: assert property (
		$rose(o_supply.bias_supply_enable) |-> o_supply.video_enable)
		else $error("bias raised before video runs");
	a_video_powered: assert property (
		o_supply.video_enable |-> o_supply.logic_supply_enable)
		else $error("video driven into unpowered panel");
	a_reset_clears: assert property (disable iff (1'b0)
		!i_rst_n |=> o_supply == SUPPLY_OFF && !o_busy && !o_power_good)
		else $error("outputs not cleared by reset");
	a_start_on_request: assert property (
		$rose(o_supply.logic_supply_enable) |-> $past(i_power_request))
		else $error("power-up without request");
	a_down_order: assert property (
		$fell(o_supply.bias_supply_enable) |-> !o_supply.video_enable)
		else $error("bias removed while video runs");
	a_good_means_on: assert property (
		o_power_good |-> o_supply.logic_supply_enable &&
		o_supply.bias_supply_enable && o_supply.video_enable)
		else $error("power good with a rail off");
	a_up_interval: assert property (
		s_video_up |-> up_q >= UP_LO && up_q <= UP_HI)
		else $error("first interval length wrong");
	a_up_bounded: assert property (
		s_start_fixed |-> ##[1:UP_HI] s_video_up)
		else $error("video not started in time");
	a_loss_drops: assert property (
		(ia_q > LOS_HI || ib_q > LOS_HI) |->
		!o_supply.logic_supply_enable)
		else $error("supply kept after signal loss");
endmodule

bind lpps_sequencer lpps_seq_monitor #(.P_MS_CYCLES(P_MS_CYCLES)) u_mon (
	.i_mclk(i_mclk),
	.i_rst_n(i_rst_n),
	.i_mode(i_mode),
	.i_passive_panel(i_passive_panel),
	.i_power_request(i_power_request),
	.i_video(i_video),
	.o_supply(o_supply),
	.o_power_good(o_power_good),
	.o_busy(o_busy)
);

// ### verification/lpps_panel_model.sv
module lpps_panel_model
	import lpps_pkg::*;
(
	input  wire logic             i_mclk,
	input  wire logic [3:0]       i_run,
	output lpps_pkg::lpps_video_s o_video
);
	timeunit 1ns;
	timeprecision 1ns;
	lpps_video_s vid_q = '0;

	// A stopped line freezes at its last level, as a halted clock does.
	always @(posedge i_mclk) begin
		vid_q <= vid_q ^ lpps_video_s'(i_run);
	end
	assign o_video = vid_q;
endmodule

// ### verification/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import lpps_pkg::*;

	localparam int P = 10;
	logic         clk     = 1'b0;
	logic         rst_n   = 1'b0;
	lpps_mode_e   mode    = LPPS_MODE_FIXED32;
	logic         passive = 1'b0;
	logic         req     = 1'b0;
	logic [3:0]   up_sel  = 4'h8;
	logic [3:0]   dn_sel  = 4'h1;
	logic [3:0]   run     = 4'hF;
	logic         ce      = 1'b1;
	logic         sig_act;
	lpps_video_s  video;
	lpps_supply_s supply;
	logic         pgood;
	logic         busy;
	int           err_total = 0;
	int           cmp_count = 0;
	int           n;

	always #5 clk = ~clk;

	lpps_sequencer #(.P_MS_CYCLES(P)) DUT (
		.i_mclk(clk),
		.i_rst_n(rst_n),
		.i_ce(ce),
		.i_mode(mode),
		.i_passive_panel(passive),
		.i_power_request(req),
		.i_up_delay_sel(up_sel),
		.i_down_delay_sel(dn_sel),
		.i_video(video),
		.o_supply(supply),
		.o_signals_active(sig_act),
		.o_power_good(pgood),
		.o_busy(busy)
	);
	lpps_panel_model u_panel (.i_mclk(clk), .i_run(run), .o_video(video));

	task automatic conclude;
		$display("Compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Durations jitter by a tick since the prescaler runs free.
	task automatic chk_rng(input int got, input int lo, input int hi);
		cmp_count++;
		if (got < lo || got > hi) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got,
			         lo, hi);
		end
	endtask

	// Waits for power good, logic rail off, or sequencing done.
	task automatic wait_on(input int s);
		n = 0;
		while (n < 4000 && !(s == 0 ? pgood === 1'b1 : s == 1 ?
			supply.logic_supply_enable === 1'b0 : busy === 1'b0)) begin
			@(negedge clk);
			n++;
		end
		// A wait that runs out is a failure, not a silent pass-through.
		if (n >= 4000) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, s);
		end
	endtask

	task automatic t_cycle(input lpps_mode_e m, input int up, input int dn);
		mode = m;
		req = 1'b1;
		wait_on(0);
		chk_rng(n, (up - 3) * P, up * P + 12);
		chk(supply, 8'hFF);
		req = 1'b0;
		wait_on(1);
		chk_rng(n, (dn - 2) * P, dn * P + 10);
		wait_on(2);
		chk(supply, 8'h00);
	endtask

	// A request dropped during power-up only takes effect once on.
	task automatic t_midreq;
		req = 1'b1;
		repeat (4) @(negedge clk);
		req = 1'b0;
		wait_on(0);
		chk({7'h00, pgood}, 8'h01);
		wait_on(1);
		wait_on(2);
		chk(supply, 8'h00);
	endtask

	task automatic t_loss;
		req = 1'b1;
		wait_on(0);
		run = 4'h0;
		wait_on(1);
		chk_rng(n, 27 * P, 30 * P + 8);
		chk(supply, 8'h00);
		run = 4'hF;
		wait_on(0);
		chk({7'h00, pgood}, 8'h01);
		req = 1'b0;
		wait_on(1);
		wait_on(2);
	endtask

	// One line missing blocks power; passive panels watch data clocks.
	// The request comes only once the stopped sync is seen idle, so a
	// start on the stale activity of the previous run cannot hide a fault.
	task automatic t_pair;
		run = 4'h8;
		repeat (40 * P) @(negedge clk);
		req = 1'b1;
		repeat (40 * P) @(negedge clk);
		chk(supply, 8'h00);
		chk({7'h00, sig_act}, 8'h00);
		passive = 1'b1;
		run = 4'h3;
		wait_on(0);
		chk(supply, 8'hFF);
		chk({7'h00, sig_act}, 8'h01);
		req = 1'b0;
		wait_on(1);
		wait_on(2);
		passive = 1'b0;
		run = 4'hF;
	endtask

	// A low clock enable must freeze a powered panel against a drop.
	task automatic t_hold;
		req = 1'b1;
		wait_on(0);
		ce = 1'b0;
		req = 1'b0;
		repeat (50) @(negedge clk);
		chk(supply, 8'hFF);
		chk({7'h00, pgood}, 8'h01);
		ce = 1'b1;
		wait_on(1);
		wait_on(2);
		chk(supply, 8'h00);
	endtask

	task automatic t_rst;
		req = 1'b1;
		wait_on(0);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		chk(supply, 8'h00);
		chk({7'h00, busy}, 8'h00);
		req = 1'b0;
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask

	initial begin
		repeat (12) @(negedge clk);
		chk(supply, 8'h00);
		rst_n = 1'b1;
		@(negedge clk);
		t_cycle(LPPS_MODE_FIXED32, 64, 64);
		t_cycle(LPPS_MODE_FIXED37, 74, 74);
		t_cycle(LPPS_MODE_SINGLE30, 60, 60);
		t_cycle(LPPS_MODE_PROG, 64, 64);
		up_sel = 4'hF;
		dn_sel = 4'h2;
		t_cycle(LPPS_MODE_PROG, 120, 128);
		t_cycle(LPPS_MODE_SMALL_AV, 25, 20);
		t_midreq;
		t_loss;
		t_pair;
		t_hold;
		t_rst;
		conclude();
	end

	// The sequence needs about 15000 cycles; this leaves wide margin.
	initial begin
		#400000;
		err_total++;
		conclude();
	end
endmodule
